// [design/wake_timer_consts.svh]
`ifndef WAKE_TIMER_CONSTS_SVH
`define WAKE_TIMER_CONSTS_SVH
// register indexes, byte address is four times the index
`define WT_IDX_RELOAD_HIGH 6'h24
`define WT_IDX_RELOAD_LOW  6'h25
`define WT_IDX_COUNT_HIGH  6'h26
`define WT_IDX_COUNT_LOW   6'h27
`define WT_IDX_CONTROL     6'h30
`define WT_IDX_STATUS      6'h31
// control and status field positions
`define WT_CTRL_RUN_BIT    7
`define WT_CTRL_QUAL_BIT   6
`define WT_CTRL_AUTO_BIT   3
`define WT_CTRL_CLK_HI     1
`define WT_CTRL_CLK_LO     0
`define WT_STAT_FLAG_BIT   0
// low-frequency oscillator divide ratios
`define WT_DIV_1           6'h01
`define WT_DIV_8           6'h08
`define WT_DIV_16          6'h10
`define WT_DIV_32          6'h20
// reset values
`define WT_RELOAD_RESET    16'h0000
`define WT_COUNT_RESET     16'h0000
`endif

// [design/wake_timer_pkg.sv]
package wake_timer_pkg;
    // wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
    // timer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } timer_state_t;
    typedef logic [1:0] clk_sel_t;
endpackage : wake_timer_pkg

// [design/wakeup_timer_reload_counter.sv]
`timescale 1ns/1ps
`include "wake_timer_consts.svh"
module wakeup_timer_reload_counter (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire wake_timer_pkg::wb_req_t wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // low-frequency oscillator tick, one clock per oscillator period
    input  wire logic                    lfo_tick_i,
    // status out
    output logic                         underflow_flag_o,
    output logic                         running_o
);
    import wake_timer_pkg::*;

    // ratio of selected clock, used by the tick logic
    function automatic logic [5:0] div_limit(input clk_sel_t s);
        case (s)
            2'b00:   div_limit = `WT_DIV_1;
            2'b01:   div_limit = `WT_DIV_8;
            2'b10:   div_limit = `WT_DIV_16;
            default: div_limit = `WT_DIV_32;
        endcase
    endfunction : div_limit

    logic [31:0]  dat_ff;
    logic [31:0]  nxt_dat;
    logic         ack_ff;
    logic         nxt_ack;
    logic [15:0]  reload_ff;
    logic [15:0]  nxt_reload;
    logic [15:0]  count_ff;
    logic [15:0]  nxt_count;
    logic [4:0]   div_cnt_ff;
    logic [4:0]   nxt_div_cnt;
    logic         auto_ff;
    logic         nxt_auto;
    clk_sel_t     sel_ff;
    clk_sel_t     nxt_sel;
    logic         flag_ff;
    logic         nxt_flag;
    timer_state_t state_ff;
    timer_state_t nxt_state;
    logic [5:0]   idx;
    logic         wr;
    logic         ctrl_wr;
    logic         start;
    logic         stop;
    logic         tick;
    logic         underflow;
    logic         running;

    // bus decode; writes land at the edge the master sees ack
    assign idx       = wb_req_i.adr[7:2];
    assign wr        = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_req_i.sel[0] & ack_ff;
    assign ctrl_wr   = wr && idx == `WT_IDX_CONTROL;
    assign running   = state_ff == ST_RUN;
    assign start     = ctrl_wr & wb_req_i.dat[`WT_CTRL_QUAL_BIT] & wb_req_i.dat[`WT_CTRL_RUN_BIT];
    assign stop      = ctrl_wr & wb_req_i.dat[`WT_CTRL_QUAL_BIT] & ~wb_req_i.dat[`WT_CTRL_RUN_BIT];
    assign tick      = running & lfo_tick_i & ({1'b0, div_cnt_ff} == div_limit(sel_ff) - 6'h01);
    assign underflow = tick & (count_ff == 16'h0000);

    // bus answer: one wait cycle, ack for exactly one cycle
    always_comb
    begin
        nxt_ack = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
        nxt_dat = 32'h0000_0000;
        case (idx)
            `WT_IDX_RELOAD_HIGH: nxt_dat[7:0] = reload_ff[15:8];
            `WT_IDX_RELOAD_LOW:  nxt_dat[7:0] = reload_ff[7:0];
            `WT_IDX_COUNT_HIGH:  nxt_dat[7:0] = count_ff[15:8];
            `WT_IDX_COUNT_LOW:   nxt_dat[7:0] = count_ff[7:0];
            `WT_IDX_CONTROL:     nxt_dat[7:0] = {running, 3'h0, auto_ff, 1'b0, sel_ff};
            `WT_IDX_STATUS:      nxt_dat[0]   = flag_ff;
            default:             nxt_dat      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // timer, configuration and flag next values
    always_comb
    begin
        nxt_reload  = reload_ff;
        nxt_auto    = auto_ff;
        nxt_sel     = sel_ff;
        nxt_count   = count_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_state   = state_ff;
        nxt_flag    = flag_ff;
        if (wr && idx == `WT_IDX_RELOAD_HIGH)
            nxt_reload[15:8] = wb_req_i.dat[7:0];
        if (wr && idx == `WT_IDX_RELOAD_LOW)
            nxt_reload[7:0] = wb_req_i.dat[7:0];
        if (ctrl_wr)
        begin
            nxt_auto = wb_req_i.dat[`WT_CTRL_AUTO_BIT];
            nxt_sel  = wb_req_i.dat[`WT_CTRL_CLK_HI:`WT_CTRL_CLK_LO];
        end
        // write one clears; a same-cycle underflow wins below
        if (wr && idx == `WT_IDX_STATUS && wb_req_i.dat[`WT_STAT_FLAG_BIT])
            nxt_flag = 1'b0;
        // prescaler counts oscillator ticks while running
        if (running && lfo_tick_i)
            nxt_div_cnt = tick ? 5'h00 : div_cnt_ff + 5'h01;
        case (state_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    nxt_count   = reload_ff;
                    nxt_div_cnt = 5'h00;
                    nxt_state   = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // reload bytes copied to the count only on start and on auto restart
                if (start)
                begin
                    nxt_count   = reload_ff;
                    nxt_div_cnt = 5'h00;
                end
                else if (stop)
                    nxt_state = ST_IDLE;
                else if (underflow)
                begin
                    if (auto_ff)
                        nxt_count = reload_ff;
                    else
                        nxt_state = ST_IDLE;
                end
                else if (tick)
                    nxt_count = count_ff - 16'h0001;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (underflow)
            nxt_flag = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reload_ff  <= `WT_RELOAD_RESET;
            count_ff   <= `WT_COUNT_RESET;
            div_cnt_ff <= 5'h00;
            auto_ff    <= 1'b0;
            sel_ff     <= 2'b00;
            flag_ff    <= 1'b0;
            state_ff   <= ST_IDLE;
        end
        else
        begin
            reload_ff  <= nxt_reload;
            count_ff   <= nxt_count;
            div_cnt_ff <= nxt_div_cnt;
            auto_ff    <= nxt_auto;
            sel_ff     <= nxt_sel;
            flag_ff    <= nxt_flag;
            state_ff   <= nxt_state;
        end
    end

    // outputs straight from flip-flops
    assign wb_dat_o         = dat_ff;
    assign wb_ack_o         = ack_ff;
    assign underflow_flag_o = flag_ff;
    assign running_o        = state_ff[1]; // one-hot run bit, no gate in the path

    chk_reload_high_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == `WT_IDX_RELOAD_HIGH |=> reload_ff[15:8] == $past(wb_req_i.dat[7:0]))
        else $error("reload high byte not stored");
    chk_reload_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == `WT_IDX_RELOAD_LOW |=> reload_ff[7:0] == $past(wb_req_i.dat[7:0]))
        else $error("reload low byte not stored");
    chk_start_loads_count: assert property (@(posedge clk_i) disable iff (rst_i)
        start |=> running && count_ff == $past(reload_ff) && div_cnt_ff == 5'h00)
        else $error("start did not load reload value");
    chk_reload_no_disturb: assert property (@(posedge clk_i) disable iff (rst_i)
        running && !start && !tick && wr && idx inside {`WT_IDX_RELOAD_HIGH, `WT_IDX_RELOAD_LOW}
        |=> $stable(count_ff))
        else $error("reload write disturbed running count");
    chk_count_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req_i.cyc && wb_req_i.stb && !ack_ff && idx == `WT_IDX_COUNT_HIGH
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(count_ff[15:8])})
        else $error("count high read wrong");
    chk_count_low_read: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req_i.cyc && wb_req_i.stb && !ack_ff && idx == `WT_IDX_COUNT_LOW
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(count_ff[7:0])})
        else $error("count low read wrong");
    chk_prescale_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
        running && lfo_tick_i && !start && !tick |=> div_cnt_ff == $past(div_cnt_ff) + 5'h01)
        else $error("prescaler step wrong");
    chk_auto_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        underflow && !ctrl_wr |=> (running && count_ff == $past(reload_ff)) == $past(auto_ff)
        && running == $past(auto_ff))
        else $error("underflow restart or stop wrong");
    chk_underflow_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        underflow |=> underflow_flag_o [*2] or (underflow_flag_o ##1 1'b1))
        else $error("underflow flag not set");
    chk_qualifier_needed: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr && !wb_req_i.dat[`WT_CTRL_QUAL_BIT] && !underflow |=> $stable(running_o))
        else $error("running changed without qualifier");
    chk_decrement_one: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && !underflow && !ctrl_wr |=> count_ff == $past(count_ff) - 16'h0001)
        else $error("count did not decrement by one");
endmodule : wakeup_timer_reload_counter

// [testbench/wakeup_timer_reload_counter_tb.sv]
`timescale 1ns/1ps
module wakeup_timer_reload_counter_tb;
    import wake_timer_pkg::*;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    wb_req_t     wb_req_i   = '0;
    logic        lfo_tick_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        underflow_flag_o;
    logic        running_o;
    logic [31:0] rd;
    int          mismatches = 0;
    int          n_tests    = 0;
    // byte addresses, four times the register index
    localparam logic [7:0] A_RHI = 8'h90, A_RLO = 8'h94, A_CHI = 8'h98, A_CLO = 8'h9c;
    localparam logic [7:0] A_CTL = 8'hc0, A_STA = 8'hc4;

    // 20 MHz system clock
    always #25 clk_i = ~clk_i;

    wakeup_timer_reload_counter i_dut (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .wb_req_i         (wb_req_i),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .lfo_tick_i       (lfo_tick_i),
        .underflow_flag_o (underflow_flag_o),
        .running_o        (running_o)
    );

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // classic cycle: request held until ack is sampled, released at that edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int guard;
        guard = 0;
        @(posedge clk_i);
        wb_req_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'h1, dat:{24'h0, dat}};
        do
        begin
            @(posedge clk_i);
            guard++;
        end
        while (wb_ack_o !== 1'b1 && guard < 20);
        chk("ack", {31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_req_i <= '0;
    endtask : wb_cycle

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
        wb_cycle(1'b0, adr, 8'h00);
        chk(what, rd, {24'h0, exp});
    endtask : rd_chk

    // one-cycle oscillator pulses with a gap between them
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            lfo_tick_i <= 1'b1;
            @(posedge clk_i);
            lfo_tick_i <= 1'b0;
        end
    endtask : ticks

    task automatic start(input logic [15:0] rl, input logic [7:0] ctl);
        wb_cycle(1'b1, A_RHI, rl[15:8]);
        wb_cycle(1'b1, A_RLO, rl[7:0]);
        wb_cycle(1'b1, A_CTL, ctl);
    endtask : start

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("reload high", A_RHI, 8'h00);
        rd_chk("reload low", A_RLO, 8'h00);
        rd_chk("unmapped", 8'h00, 8'h00);
        $display("test reset done");
        start(16'h1234, 8'hc0);
        rd_chk("reload high", A_RHI, 8'h12);
        rd_chk("reload low", A_RLO, 8'h34);
        rd_chk("count high", A_CHI, 8'h12);
        rd_chk("count low", A_CLO, 8'h34);
        wb_cycle(1'b1, A_RLO, 8'h00);
        wb_cycle(1'b1, A_CTL, 8'h00);
        rd_chk("count low", A_CLO, 8'h34);
        chk("running", {31'h0, running_o}, 32'h1);
        ticks(1);
        rd_chk("count low", A_CLO, 8'h33);
        rd_chk("count high", A_CHI, 8'h12);
        wb_cycle(1'b1, A_CTL, 8'h40);
        @(posedge clk_i);
        chk("running", {31'h0, running_o}, 32'h0);
        $display("test load done");
        // every divide ratio: the count moves only on the ratio-th pulse
        for (int s = 0; s < 4; s++)
        begin
            start(16'h0005, {6'b110000, s[1:0]});
            ticks((s == 0) ? 0 : (4 << s) - 1);
            rd_chk("count low", A_CLO, 8'h05);
            ticks(1);
            rd_chk("count low", A_CLO, 8'h04);
        end
        $display("test divide done");
        start(16'h0001, 8'hc0);
        ticks(2);
        repeat (2) @(posedge clk_i);
        chk("flag", {31'h0, underflow_flag_o}, 32'h1);
        chk("running", {31'h0, running_o}, 32'h0);
        rd_chk("count low", A_CLO, 8'h00);
        wb_cycle(1'b1, A_STA, 8'h01);
        @(posedge clk_i);
        chk("flag", {31'h0, underflow_flag_o}, 32'h0);
        wb_cycle(1'b1, A_CTL, 8'h80);
        @(posedge clk_i);
        chk("running", {31'h0, running_o}, 32'h0);
        rd_chk("control", A_CTL, 8'h00);
        start(16'h0002, 8'hc8);
        ticks(3);
        repeat (2) @(posedge clk_i);
        chk("flag", {31'h0, underflow_flag_o}, 32'h1);
        chk("running", {31'h0, running_o}, 32'h1);
        rd_chk("count low", A_CLO, 8'h02);
        rd_chk("control", A_CTL, 8'h88);
        rd_chk("status", A_STA, 8'h01);
        $display("test underflow done");
        report_and_stop();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
endmodule : wakeup_timer_reload_counter_tb
